/* rtl/flash_cmd_pkg.sv */
// shared constants, types and protect decode for the erase and power-down command logic
package flash_cmd_pkg;

  // -------------------------------------------------------------------
  // opcodes
  // -------------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ     = 8'h05;
  localparam logic [7:0] OP_BLOCK32_ERASE   = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE   = 8'hD8;
  localparam logic [7:0] OP_ARRAY_ERASE_A   = 8'h60;
  localparam logic [7:0] OP_ARRAY_ERASE_B   = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP      = 8'hB9;
  localparam logic [7:0] OP_WAKE_AND_ID     = 8'hAB;

  // -------------------------------------------------------------------
  // frame lengths, field positions and masks
  // -------------------------------------------------------------------
  localparam int          ADDR_W         = 24;
  localparam int          BITCNT_W       = 6;
  localparam logic [5:0]  OPCODE_BITS    = 6'h08;
  localparam logic [5:0]  ADDR_CMD_BITS  = 6'h20;
  localparam int          BLOCK_IDX_LSB  = 16;
  localparam int          BLOCK_IDX_MSB  = 19;
  localparam int          PROTECT_SIDE   = 3;
  localparam int          STATUS_WIP_BIT = 0;
  localparam int          STATUS_WEL_BIT = 1;
  localparam logic [2:0]  STATUS_TOP     = 3'h7;
  localparam logic [23:0] BLOCK64_MASK   = 24'hFF0000;
  localparam logic [23:0] BLOCK32_MASK   = 24'hFF8000;

  // -------------------------------------------------------------------
  // timing: times in ns, counts derived from the 8 ns clock
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 8;
  localparam int BLOCK_ERASE_TIME_NS    = 1000000;
  localparam int ARRAY_ERASE_TIME_NS    = 10000000;
  localparam int SLEEP_ENTRY_DELAY_NS   = 3000;
  localparam int WAKE_RECOVERY_NS       = 3000;
  localparam int BLOCK_ERASE_CYCLES     = BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int ARRAY_ERASE_CYCLES     = ARRAY_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYCLES     = SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS;
  localparam int WAKE_RECOVERY_CYCLES   = WAKE_RECOVERY_NS / CLK_PERIOD_NS;

  // erase kinds on the erase request port
  typedef enum logic [1:0] {
    ERASE_BLOCK32 = 2'h1,
    ERASE_BLOCK64 = 2'h2,
    ERASE_ARRAY   = 2'h3
  } erase_kind_t;

  // 64 KB block index against the protected span, top or bottom, complement inverts
  function automatic logic block_protected(input logic [23:0] addr,
                                           input logic [4:0]  field,
                                           input logic        cmp);
    logic [4:0] span;
    logic [4:0] blk;
    logic       hit;
    span = (field[2:0] == 3'h0) ? 5'h00 :
           (field[2:0] >= 3'h5) ? 5'h10 : 5'(5'h01 << (field[2:0] - 3'h1));
    blk  = {1'b0, addr[BLOCK_IDX_MSB:BLOCK_IDX_LSB]};
    hit  = field[PROTECT_SIDE] ? (blk < span) : (blk >= 5'(5'h10 - span));
    return hit ^ cmp;
  endfunction

  // whole array free of protection
  function automatic logic array_unprotected(input logic [4:0] field, input logic cmp);
    return ((field[2:0] == 3'h0) && !cmp) || ((field[2:0] >= 3'h5) && cmp);
  endfunction

endpackage

/* rtl/spi_frame_shifter.sv */
// serial input shifter and bit counter for one chip-select frame
`timescale 1ns/1ps
module spi_frame_shifter #(
  parameter int DATA_W = 32,
  parameter int CNT_W  = 6
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              si,
  output logic [DATA_W-1:0]      shift_reg,
  output logic [CNT_W-1:0]       bit_count_reg,
  output logic                   sclk_fall,
  output logic                   frame_end
);

  logic sclk_prev_reg;
  logic cs_prev_reg;
  logic sclk_rise;

  // --------------------------------------------------------------------
  // edges of the serial clock and chip select
  // --------------------------------------------------------------------
  assign sclk_rise = sclk && !sclk_prev_reg && !cs_n;
  assign sclk_fall = !sclk && sclk_prev_reg && !cs_n;
  assign frame_end = cs_n && !cs_prev_reg;

  // previous levels, idle high for chip select
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end
    else
    begin
      sclk_prev_reg <= sclk;
      cs_prev_reg   <= cs_n;
    end
  end

  // msb first shift on each rising serial edge
  always_ff @(posedge clk)
  begin
    if (rst)
      shift_reg <= '0;
    else if (sclk_rise)
      shift_reg <= {shift_reg[DATA_W-2:0], si};
  end

  // count held through the frame end cycle, cleared while deselected
  always_ff @(posedge clk)
  begin
    if (rst)
      bit_count_reg <= '0;
    else if (cs_n)
      bit_count_reg <= '0;
    else if (sclk_rise && (bit_count_reg != {CNT_W{1'b1}}))
      bit_count_reg <= bit_count_reg + 1'b1; // saturates so odd lengths never wrap to 8 or 32
  end

endmodule // spi_frame_shifter

/* rtl/cycle_timer.sv */
// down counter that times the self-timed cycles and power-state delays
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          load,
  input  wire logic [W-1:0]  count_in,
  output logic               done_reg
);

  logic [W-1:0] remain_reg;

  // load wins over the running count
  always_ff @(posedge clk)
  begin
    if (rst)
      remain_reg <= '0;
    else if (load)
      remain_reg <= count_in;
    else if (remain_reg != '0)
      remain_reg <= remain_reg - 1'b1;
  end

  // one-cycle pulse as the count runs out
  always_ff @(posedge clk)
  begin
    if (rst)
      done_reg <= 1'b0;
    else
      done_reg <= !load && (remain_reg == {{(W-1){1'b0}}, 1'b1});
  end

endmodule // cycle_timer

/* rtl/flash_erase_powerdown_cmds.sv */
// command decode for block erase, array erase and deep sleep in the serial flash
`timescale 1ns/1ps
module flash_erase_powerdown_cmds #(
  parameter int BLOCK_ERASE_CYCLES   = flash_cmd_pkg::BLOCK_ERASE_CYCLES,
  parameter int ARRAY_ERASE_CYCLES   = flash_cmd_pkg::ARRAY_ERASE_CYCLES,
  parameter int SLEEP_ENTRY_CYCLES   = flash_cmd_pkg::SLEEP_ENTRY_CYCLES,
  parameter int WAKE_RECOVERY_CYCLES = flash_cmd_pkg::WAKE_RECOVERY_CYCLES,
  parameter int TIMER_W              = 32
) (
  input  wire logic         SYS_CLK,
  input  wire logic         RESET,
  input  wire logic         CS_N,
  input  wire logic         SCLK,
  input  wire logic         SI,
  input  wire logic [4:0]   PROTECT_FIELD,
  input  wire logic         PROTECT_COMPLEMENT_BIT,
  output logic              SO,
  output logic              SO_OE_N,
  output logic              WRITE_ENABLE_LATCH,
  output logic              WRITE_IN_PROGRESS_FLAG,
  output logic              DEEP_SLEEP,
  output logic              ERASE_START,
  output logic [1:0]        ERASE_KIND,
  output logic [23:0]       ERASE_BASE
);

  // --------------------------------------------------------------------
  // power and cycle states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STANDBY     = 3'h0,
    ST_ERASE_BUSY  = 3'h1,
    ST_SLEEP_ENTRY = 3'h4,
    ST_DEEP_SLEEP  = 3'h6,
    ST_WAKING      = 3'h2
  } power_state_t;

  power_state_t                        state_reg;
  power_state_t                        state_next;
  logic [31:0]                         shift_word;
  logic [flash_cmd_pkg::BITCNT_W-1:0]  bit_count;
  logic                                sclk_fall;
  logic                                frame_end;
  logic                                timer_done;
  logic                                timer_load;
  logic [TIMER_W-1:0]                  timer_count;
  logic [7:0]                          opcode_reg;
  logic [7:0]                          op_now;
  logic [23:0]                         addr_now;
  logic                                frame8;
  logic                                frame32;
  logic                                in_standby;
  logic                                blk_prot;
  logic                                chip_ok;
  logic                                accept_block32;
  logic                                accept_block64;
  logic                                accept_array;
  logic                                accept_sleep;
  logic                                accept_wake;
  logic                                erase_go;
  logic                                wel_set;
  logic                                wel_clr;
  logic                                status_mode;
  logic [7:0]                          status_byte;
  logic                                wel_reg;
  logic                                wip_reg;
  logic                                sleep_reg;
  logic                                so_reg;
  logic                                so_oe_n_reg;
  logic                                erase_start_reg;
  logic [1:0]                          erase_kind_reg;
  logic [23:0]                         erase_base_reg;

  // --------------------------------------------------------------------
  // serial front end and cycle timer
  // --------------------------------------------------------------------
  spi_frame_shifter #(
    .DATA_W (32),
    .CNT_W  (flash_cmd_pkg::BITCNT_W)
  ) u_shifter (
    .clk           (SYS_CLK),
    .rst           (RESET),
    .cs_n          (CS_N),
    .sclk          (SCLK),
    .si            (SI),
    .shift_reg     (shift_word),
    .bit_count_reg (bit_count),
    .sclk_fall     (sclk_fall),
    .frame_end     (frame_end)
  );

  cycle_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clk      (SYS_CLK),
    .rst      (RESET),
    .load     (timer_load),
    .count_in (timer_count),
    .done_reg (timer_done)
  );

  // --------------------------------------------------------------------
  // frame decode
  // --------------------------------------------------------------------
  // opcode is live in the low byte while exactly 8 bits are in, held after
  assign op_now   = (bit_count == flash_cmd_pkg::OPCODE_BITS) ? shift_word[7:0] : opcode_reg;
  assign addr_now = shift_word[23:0];
  // only exact lengths count: one bit short or long kills the command
  assign frame8     = frame_end && (bit_count == flash_cmd_pkg::OPCODE_BITS);
  assign frame32    = frame_end && (bit_count == flash_cmd_pkg::ADDR_CMD_BITS);
  assign in_standby = (state_reg == ST_STANDBY);
  assign blk_prot   = flash_cmd_pkg::block_protected(addr_now, PROTECT_FIELD,
                                                     PROTECT_COMPLEMENT_BIT);
  assign chip_ok    = flash_cmd_pkg::array_unprotected(PROTECT_FIELD, PROTECT_COMPLEMENT_BIT);

  // erase acceptance: latch set, not protected, nothing running
  assign accept_block32 = frame32 && in_standby && wel_reg && !blk_prot
                          && (op_now == flash_cmd_pkg::OP_BLOCK32_ERASE);
  assign accept_block64 = frame32 && in_standby && wel_reg && !blk_prot
                          && (op_now == flash_cmd_pkg::OP_BLOCK64_ERASE);
  // array erase only with the whole array unprotected
  assign accept_array   = frame8 && in_standby && wel_reg && chip_ok
                          && ((op_now == flash_cmd_pkg::OP_ARRAY_ERASE_A)
                           || (op_now == flash_cmd_pkg::OP_ARRAY_ERASE_B));
  assign erase_go       = accept_block32 || accept_block64 || accept_array;

  // sleep only from standby, so a running cycle rejects it
  assign accept_sleep = frame8 && in_standby && (op_now == flash_cmd_pkg::OP_DEEP_SLEEP);
  // wake also accepts the id form with trailing dummy bytes
  assign accept_wake  = frame_end && (state_reg == ST_DEEP_SLEEP)
                        && (bit_count >= flash_cmd_pkg::OPCODE_BITS)
                        && (op_now == flash_cmd_pkg::OP_WAKE_AND_ID);

  // write enable latch commands, honoured in standby only
  assign wel_set = frame8 && in_standby && (op_now == flash_cmd_pkg::OP_WRITE_LATCH_SET);
  assign wel_clr = (frame8 && in_standby && (op_now == flash_cmd_pkg::OP_WRITE_LATCH_CLR))
                   || erase_go;

  // --------------------------------------------------------------------
  // state transitions
  // --------------------------------------------------------------------
  // a plain deselect never leaves standby; only accepted commands move it
  always_comb
  begin
    state_next  = state_reg;
    timer_load  = 1'b0;
    timer_count = '0;
    unique case (state_reg)
      ST_STANDBY:
      begin
        if (erase_go)
        begin
          state_next  = ST_ERASE_BUSY;
          timer_load  = 1'b1;
          timer_count = accept_array ? TIMER_W'(ARRAY_ERASE_CYCLES)
                                     : TIMER_W'(BLOCK_ERASE_CYCLES);
        end
        else if (accept_sleep)
        begin
          state_next  = ST_SLEEP_ENTRY;
          timer_load  = 1'b1;
          timer_count = TIMER_W'(SLEEP_ENTRY_CYCLES);
        end
      end
      ST_ERASE_BUSY:
      begin
        if (timer_done)
          state_next = ST_STANDBY;
      end
      ST_SLEEP_ENTRY:
      begin
        if (timer_done)
          state_next = ST_DEEP_SLEEP;
      end
      ST_DEEP_SLEEP:
      begin
        // everything but the wake opcode falls through here
        if (accept_wake)
        begin
          state_next  = ST_WAKING;
          timer_load  = 1'b1;
          timer_count = TIMER_W'(WAKE_RECOVERY_CYCLES);
        end
      end
      ST_WAKING:
      begin
        if (timer_done)
          state_next = ST_STANDBY;
      end
      default:
        state_next = ST_STANDBY;
    endcase
  end

  // reset stands in for power-up, so deep sleep never survives it
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      state_reg <= ST_STANDBY;
    else
      state_reg <= state_next;
  end

  // opcode holder for frames longer than one byte
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      opcode_reg <= 8'h00;
    else if (bit_count == flash_cmd_pkg::OPCODE_BITS)
      opcode_reg <= shift_word[7:0];
  end

  // --------------------------------------------------------------------
  // write enable latch and busy flag
  // --------------------------------------------------------------------
  // erase start clears the latch at the very start of the cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      wel_reg <= 1'b0;
    else if (wel_set)
      wel_reg <= 1'b1;
    else if (wel_clr)
      wel_reg <= 1'b0;
  end

  // busy flag tracks the erase state one edge behind its decision
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      wip_reg   <= 1'b0;
      sleep_reg <= 1'b0;
    end
    else
    begin
      wip_reg   <= (state_next == ST_ERASE_BUSY);
      sleep_reg <= (state_next == ST_DEEP_SLEEP) || (state_next == ST_WAKING);
    end
  end

  // --------------------------------------------------------------------
  // erase request to the array
  // --------------------------------------------------------------------
  // base is the block start, so any address inside picks the block
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      erase_start_reg <= 1'b0;
      erase_kind_reg  <= 2'h0;
      erase_base_reg  <= 24'h000000;
    end
    else
    begin
      erase_start_reg <= erase_go;
      if (accept_block32)
      begin
        erase_kind_reg <= flash_cmd_pkg::ERASE_BLOCK32;
        erase_base_reg <= addr_now & flash_cmd_pkg::BLOCK32_MASK;
      end
      else if (accept_block64)
      begin
        erase_kind_reg <= flash_cmd_pkg::ERASE_BLOCK64;
        erase_base_reg <= addr_now & flash_cmd_pkg::BLOCK64_MASK;
      end
      else if (accept_array)
      begin
        erase_kind_reg <= flash_cmd_pkg::ERASE_ARRAY;
        erase_base_reg <= 24'h000000;
      end
    end
  end

  // --------------------------------------------------------------------
  // status read path
  // --------------------------------------------------------------------
  // served in standby and while busy so the host can poll; sclk must be
  // at most half the system clock for the falling edge to be seen
  assign status_mode = !CS_N && (bit_count >= flash_cmd_pkg::OPCODE_BITS)
                       && (op_now == flash_cmd_pkg::OP_STATUS_READ)
                       && ((state_reg == ST_STANDBY) || (state_reg == ST_ERASE_BUSY));

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[flash_cmd_pkg::STATUS_WIP_BIT] = wip_reg;
    status_byte[flash_cmd_pkg::STATUS_WEL_BIT] = wel_reg;
  end

  // bits go out on falling edges, msb first, repeating every byte
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      so_reg      <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end
    else
    begin
      so_oe_n_reg <= !status_mode;
      if (status_mode && sclk_fall)
        so_reg <= status_byte[3'(flash_cmd_pkg::STATUS_TOP - bit_count[2:0])];
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign SO                     = so_reg;
  assign SO_OE_N                = so_oe_n_reg;
  assign WRITE_ENABLE_LATCH     = wel_reg;
  assign WRITE_IN_PROGRESS_FLAG = wip_reg;
  assign DEEP_SLEEP             = sleep_reg;
  assign ERASE_START            = erase_start_reg;
  assign ERASE_KIND             = erase_kind_reg;
  assign ERASE_BASE             = erase_base_reg;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  localparam int CHK_SLEEP_MAX = SLEEP_ENTRY_CYCLES + 3;

  default clocking chk_cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence seq_block_cmd;
    frame32 && in_standby && wel_reg && !blk_prot
      && ((op_now == flash_cmd_pkg::OP_BLOCK32_ERASE)
       || (op_now == flash_cmd_pkg::OP_BLOCK64_ERASE));
  endsequence

  sequence seq_sleep_cmd;
    frame8 && in_standby && (op_now == flash_cmd_pkg::OP_DEEP_SLEEP);
  endsequence

  chk_block_starts: assert property (seq_block_cmd |=> ERASE_START ##0 WRITE_IN_PROGRESS_FLAG)
    else $error("accepted block erase did not start");
  chk_block_base: assert property (ERASE_START && (ERASE_KIND == flash_cmd_pkg::ERASE_BLOCK64)
    |-> (ERASE_BASE == ($past(addr_now) & flash_cmd_pkg::BLOCK64_MASK)))
    else $error("64 KB erase base wrong");
  chk_latch_needed: assert property (ERASE_START |-> $past(wel_reg) && !WRITE_ENABLE_LATCH)
    else $error("erase without latch or latch kept");
  chk_block_length: assert property (ERASE_START && (ERASE_KIND != flash_cmd_pkg::ERASE_ARRAY)
    |-> $past(bit_count) == flash_cmd_pkg::ADDR_CMD_BITS)
    else $error("block erase with wrong bit count");
  chk_busy_clears: assert property (WRITE_IN_PROGRESS_FLAG |-> !WRITE_ENABLE_LATCH)
    else $error("latch set again during erase");
  chk_busy_done: assert property ((state_reg == ST_ERASE_BUSY) && timer_done
    |=> !WRITE_IN_PROGRESS_FLAG && in_standby)
    else $error("busy flag not cleared on completion");
  chk_block_protect: assert property (frame32 && blk_prot |=> !ERASE_START)
    else $error("protected block erased");
  chk_array_protect: assert property (ERASE_START && (ERASE_KIND == flash_cmd_pkg::ERASE_ARRAY)
    |-> $past(chip_ok) && ($past(bit_count) == flash_cmd_pkg::OPCODE_BITS))
    else $error("array erase with protection or bad length");
  chk_status_served: assert property ((state_reg == ST_ERASE_BUSY) && !CS_N
    && (bit_count >= flash_cmd_pkg::OPCODE_BITS)
    && (op_now == flash_cmd_pkg::OP_STATUS_READ) |=> !SO_OE_N)
    else $error("status read refused while busy");
  chk_sleep_entry: assert property (seq_sleep_cmd |=> !DEEP_SLEEP [*2]
    ##[1:CHK_SLEEP_MAX] DEEP_SLEEP)
    else $error("deep sleep not entered after delay");
  chk_sleep_ignores: assert property ((state_reg == ST_DEEP_SLEEP) && frame_end
    && (op_now != flash_cmd_pkg::OP_WAKE_AND_ID) |=> (state_reg == ST_DEEP_SLEEP)
    && !ERASE_START && $stable(WRITE_ENABLE_LATCH))
    else $error("command acted on in deep sleep");
  chk_sleep_rejected: assert property ((state_reg == ST_ERASE_BUSY) && frame8
    && (op_now == flash_cmd_pkg::OP_DEEP_SLEEP)
    |=> (state_reg == ST_ERASE_BUSY) || in_standby)
    else $error("erase cycle disturbed");
  chk_standby_reset: assert property ($fell(RESET) |-> in_standby && !DEEP_SLEEP)
    else $error("not in standby after power-up");

endmodule // flash_erase_powerdown_cmds

/* tb/spi_host_model.sv */
// behavioural spi host that frames commands for the flash command logic
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clk,
  input  wire logic so,
  input  wire logic so_oe_n,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  logic [31:0] rx;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // released data line flips each cycle so a stale bit never looks driven
  always @(posedge clk) if (cs_n) si <= ~si;
  // sends the top n bits of d msb first, sclk half periods of two cycles
  task automatic frame(input logic [31:0] d, input int n);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      si   <= d[31 - i];
      sclk <= 1'b0;
      repeat (2) @(posedge clk);
      sclk <= 1'b1;
      rx   <= {rx[30:0], so_oe_n ? !so : so}; // undriven line reads inverted
      @(posedge clk);
    end
    @(posedge clk);
    sclk <= 1'b0;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule // spi_host_model

/* tb/tb_flash_erase_powerdown_cmds.sv */
// self-checking bench for the erase and deep sleep command logic
`timescale 1ns/1ps
module tb_flash_erase_powerdown_cmds;
  logic        clk, rst, cs_n, sclk, si, cmp, so, so_oe_n, write_enable_latch, write_in_progress_flag, slp, start;
  logic [4:0]  prot;
  logic [1:0]  kind;
  logic [23:0] base, addr;
  logic [7:0]  ops [4] = '{8'h52, 8'hD8, 8'h60, 8'hC7};
  int          fails, total_checks, starts;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  spi_host_model host (.clk(clk), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n), .sclk(sclk),
    .si(si));
  // erase times long enough for a status poll to land inside the busy cycle
  flash_erase_powerdown_cmds #(.BLOCK_ERASE_CYCLES(100), .ARRAY_ERASE_CYCLES(200),
    .SLEEP_ENTRY_CYCLES(10), .WAKE_RECOVERY_CYCLES(10)) dut (.SYS_CLK(clk), .RESET(rst),
    .CS_N(cs_n), .SCLK(sclk), .SI(si), .PROTECT_FIELD(prot), .PROTECT_COMPLEMENT_BIT(cmp),
    .SO(so), .SO_OE_N(so_oe_n), .WRITE_ENABLE_LATCH(write_enable_latch), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag),
    .DEEP_SLEEP(slp), .ERASE_START(start), .ERASE_KIND(kind), .ERASE_BASE(base));
  // pulses are counted so a refusal shows as no new pulse
  always @(posedge clk) if (start === 1'b1) starts <= starts + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one erase attempt, optionally after the latch set command
  task automatic erase(input logic [7:0] op, input int n, input logic we, input logic ok);
    int s0;
    s0 = starts;
    if (we) host.frame({8'h06, 24'h0}, 8);
    host.frame({op, addr}, n);
    @(posedge clk); // let the pulse counter take the start pulse first
    chk("pulse", 32'(ok), 32'(starts - s0));
    chk("latch", 32'(we & !ok), 32'(write_enable_latch));
    chk("busy", 32'(ok), 32'(write_in_progress_flag));
    if (ok) chk("kind", (op == 8'h52) ? 1 : (op == 8'hD8) ? 2 : 3, 32'(kind));
    if (ok) chk("base", (op == 8'h52) ? addr & flash_cmd_pkg::BLOCK32_MASK :
      (op == 8'hD8) ? addr & flash_cmd_pkg::BLOCK64_MASK : 0, 32'(base));
    host.frame({8'h05, 24'h0}, 16);
    chk("status", 32'({we & !ok, ok}), 32'(host.rx[7:0]));
    for (int i = 0; i < 400 && write_in_progress_flag !== 1'b0; i++) @(posedge clk);
    chk("done", 0, 32'(write_in_progress_flag));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles the tests need
  initial
  begin
    #160000;
    fails++;
    summarize();
  end
  initial
  begin
    rst = 1'b1;
    prot = 5'h00;
    cmp = 1'b0;
    void'($urandom(702));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("idle", 32'h1, {write_enable_latch, write_in_progress_flag, slp, so_oe_n});
    for (int k = 0; k < 8; k++)
    begin
      addr = 24'($urandom);
      erase(ops[k % 4], 32 - 24 * (k / 2 % 2), 1'b1, 1'b1);
    end
    erase(8'hD8, 32, 1'b0, 1'b0);
    erase(8'h52, 31, 1'b1, 1'b0);
    host.frame({8'h04, 24'h0}, 8);
    erase(8'h60, 9, 1'b1, 1'b0);
    host.frame({8'h04, 24'h0}, 8);
    $display("test framing done");
    prot <= 5'h01;
    addr = 24'h0F8000;
    erase(8'h52, 32, 1'b1, 1'b0);
    host.frame({8'h04, 24'h0}, 8);
    addr = 24'h0EFFFF;
    erase(8'hD8, 32, 1'b1, 1'b1);
    erase(8'hC7, 8, 1'b1, 1'b0);
    host.frame({8'h04, 24'h0}, 8);
    prot <= 5'h09;
    addr = 24'h00ABCD;
    erase(8'hD8, 32, 1'b1, 1'b0);
    host.frame({8'h04, 24'h0}, 8);
    prot <= 5'h06;
    cmp <= 1'b1;
    erase(8'h60, 8, 1'b1, 1'b1);
    $display("test protect done");
    prot <= 5'h00;
    cmp <= 1'b0;
    host.frame({8'h06, 24'h0}, 8);
    host.frame({8'hC7, 24'h0}, 8);
    host.frame({8'hB9, 24'h0}, 8);
    for (int i = 0; i < 400 && write_in_progress_flag !== 1'b0; i++) @(posedge clk);
    repeat (15) @(posedge clk);
    chk("busy sleep", 0, 32'(slp));
    host.frame({8'hB9, 24'h0}, 9);
    repeat (15) @(posedge clk);
    chk("long sleep", 0, 32'(slp));
    host.frame({8'hB9, 24'h0}, 8);
    chk("sleep early", 0, 32'(slp));
    repeat (12) @(posedge clk);
    chk("sleep", 1, 32'(slp));
    host.frame({8'h06, 24'h0}, 8);
    chk("latch asleep", 0, 32'(write_enable_latch));
    host.frame({8'hAB, 24'h0}, 8);
    repeat (15) @(posedge clk);
    chk("wake", 0, 32'(slp));
    erase(8'hD8, 32, 1'b1, 1'b1);
    host.frame({8'hB9, 24'h0}, 8);
    repeat (15) @(posedge clk);
    chk("sleep again", 1, 32'(slp));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("power up", 32'h1, {write_enable_latch, write_in_progress_flag, slp, so_oe_n});
    $display("test sleep done");
    summarize();
  end
endmodule // tb_flash_erase_powerdown_cmds
